/* File: dars_buf.sv */
// Small result buffer with valid and ready on both sides
`timescale 1ns/1ps
module dars_buf #(
  parameter int W     = 24,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;
  logic [CW-1:0] cnt_d;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  // Next fill level; ready is registered so the source sees a flop
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) cnt_d = cnt_q + CW'(1);
    if (pop && !push) cnt_d = cnt_q - CW'(1);
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q     <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      if (pop)  rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != CW'(DEPTH));
    end
  end

  // Storage needs no reset; it is only read while counted valid
  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule : dars_buf

/* File: dars_host.sv */
// Host serial port model: select, serial clock, bit capture
`timescale 1ns/1ps
module dars_host (
  input  wire logic        clk,
  output logic             frame_sel_b,
  output logic             sclk,
  input  wire logic        line_a,
  input  wire logic        line_b,
  output logic [31:0]      cap_a,
  output logic [31:0]      cap_b
);
  initial begin
    frame_sel_b = 1'b1;
    sclk        = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk
  // Shift the two line levels into the captures
  task automatic grab();
    cap_a = {cap_a[30:0], line_a};
    cap_b = {cap_b[30:0], line_b};
  endtask : grab
  // Serial clock idles high and stands still outside frames; a slow host
  // may capture just as the clock rises instead of just before it falls
  task automatic run(input int n, input bit on_rise);
    cap_a = '0;
    cap_b = '0;
    wait_clk(1);
    frame_sel_b = 1'b0;
    wait_clk(4);
    repeat (n) begin
      if (!on_rise) grab();
      sclk = 1'b0;
      wait_clk(4);
      if (on_rise) grab();
      sclk = 1'b1;
      wait_clk(4);
    end
    frame_sel_b = 1'b1;
    wait_clk(12); // Quiet time before the next frame
  endtask : run
endmodule : dars_host

/* File: dars_pkg.sv */
// Types and the frame word builder of the serial readout block
`include "dars_regs.svh"
package dars_pkg;
  typedef enum logic [1:0] {
    DARS_IDLE,
    DARS_FIRST,
    DARS_SECOND,
    DARS_PARKED
  } dars_state_t;

  typedef logic [`DARS_FRAME_BITS-1:0] dars_word_t;

  // Two leading zeros, result, two trailing zeros, then the other result alike
  function automatic dars_word_t dars_frame(input logic [`DARS_RES_W-1:0] own,
                                            input logic [`DARS_RES_W-1:0] other);
    dars_frame = {`DARS_ZERO_PAIR, own, `DARS_ZERO_PAIR,
                  `DARS_ZERO_PAIR, other, `DARS_ZERO_PAIR};
  endfunction : dars_frame
endpackage : dars_pkg

/* File: dars_regs.svh */
// Constants for the dual converter serial readout block
`ifndef DARS_REGS_SVH
`define DARS_REGS_SVH
`define DARS_RES_W        12
`define DARS_FRAME_BITS   32
`define DARS_CNT_W        6
`define DARS_HOLD_FALLS   6'h0d
`define DARS_CONV_FALLS   6'h0e
`define DARS_LAST_FALL    6'h20
`define DARS_CNT_ZERO     6'h00
`define DARS_CNT_ONE      6'h01
`define DARS_ZERO_PAIR    2'h0
`define DARS_SYNC_RESET   3'h7
`endif

/* File: dars_top.sv */
// Serial conversion and readout interface of a dual simultaneous converter
`timescale 1ns/1ps
`include "dars_regs.svh"
module dars_top (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   frame_sel_b,
  input  wire logic                   sclk,
  input  wire logic [`DARS_RES_W-1:0] res_first,
  input  wire logic [`DARS_RES_W-1:0] res_second,
  input  wire logic                   res_valid,
  output logic                        res_ready,
  output logic                        serial_out_first,
  output logic                        serial_out_first_oe,
  output logic                        serial_out_second,
  output logic                        serial_out_second_oe,
  output logic                        hold_q,
  output logic                        sample_q,
  output logic                        convert_q,
  output logic                        missing_q
);

  //////////////////////////////////////////////////////////////////////////
  // Decoders shared by several processes

  // Edge tests on a synchronised pin: the newer of two stages against the one before
  function automatic logic pin_fell(input logic new_lvl, input logic old_lvl);
    pin_fell = !new_lvl && old_lvl;
  endfunction : pin_fell

  function automatic logic pin_rose(input logic new_lvl, input logic old_lvl);
    pin_rose = new_lvl && !old_lvl;
  endfunction : pin_rose

  // The coming clock fall lands on a goal count in a given state; both the
  // drive enable and the conversion flag end on such a fall
  function automatic logic fall_reaches(input dars_pkg::dars_state_t st,
                                        input dars_pkg::dars_state_t want,
                                        input logic [`DARS_CNT_W-1:0] cnt,
                                        input logic [`DARS_CNT_W-1:0] goal);
    fall_reaches = (st == want) && (cnt == goal);
  endfunction : fall_reaches

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic [2:0] cs_sync_q;
  logic [2:0] ck_sync_q;
  logic       cs_fall;
  logic       cs_rise;
  logic       ck_fall;
  logic       ck_rise;

  // Stage 0 is read only by stage 1; edges compare stages 1 and 2
  // Three stages cost clocks of latency but keep metastability off the decode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync_q <= `DARS_SYNC_RESET;
      ck_sync_q <= `DARS_SYNC_RESET;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], frame_sel_b};
      ck_sync_q <= {ck_sync_q[1:0], sclk};
    end
  end

  assign cs_fall = pin_fell(cs_sync_q[1], cs_sync_q[2]);
  assign cs_rise = pin_rose(cs_sync_q[1], cs_sync_q[2]);
  assign ck_fall = pin_fell(ck_sync_q[1], ck_sync_q[2]);
  assign ck_rise = pin_rose(ck_sync_q[1], ck_sync_q[2]);

  //////////////////////////////////////////////////////////////////////////
  // Result buffer between the converter core and the shifters
  logic [2*`DARS_RES_W-1:0] buf_data;
  logic                     buf_valid;
  logic                     buf_pop;

  // A frame start drains one pair; the core stalls on res_ready
  assign buf_pop = cs_fall;

  dars_buf #(
    .W     (2*`DARS_RES_W),
    .DEPTH (2)
  ) dars_buf_inst (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   ({res_first, res_second}),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop)
  );

  //////////////////////////////////////////////////////////////////////////
  // Frame sequencing
  dars_pkg::dars_state_t     state_q;
  logic [`DARS_CNT_W-1:0]    falls_q;
  logic [`DARS_CNT_W-1:0]    falls_d;
  logic                      shifting;

  assign falls_d  = falls_q + `DARS_CNT_ONE;
  assign shifting = (state_q == dars_pkg::DARS_FIRST) ||
                    (state_q == dars_pkg::DARS_SECOND);

  // Select rise wins over any clock edge seen in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= dars_pkg::DARS_IDLE;
      falls_q <= `DARS_CNT_ZERO;
    end else if (cs_rise) begin
      state_q <= dars_pkg::DARS_IDLE;
      falls_q <= `DARS_CNT_ZERO;
    end else if (cs_fall) begin
      state_q <= dars_pkg::DARS_FIRST;
      falls_q <= `DARS_CNT_ZERO;
    end else if (ck_fall && shifting) begin
      falls_q <= falls_d;
      unique case (state_q)
        dars_pkg::DARS_FIRST: begin
          if (falls_d == `DARS_CONV_FALLS) state_q <= dars_pkg::DARS_SECOND;
        end
        dars_pkg::DARS_SECOND: begin
          if (falls_d == `DARS_LAST_FALL) state_q <= dars_pkg::DARS_PARKED;
        end
        dars_pkg::DARS_IDLE,
        dars_pkg::DARS_PARKED: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output shifters
  logic [`DARS_FRAME_BITS-1:0] sh_first_q;
  logic [`DARS_FRAME_BITS-1:0] sh_second_q;
  logic [`DARS_RES_W-1:0]      load_first;
  logic [`DARS_RES_W-1:0]      load_second;

  // An empty buffer at frame start sends zeros rather than stale data
  assign load_first  = buf_valid ? buf_data[2*`DARS_RES_W-1:`DARS_RES_W] : '0;
  assign load_second = buf_valid ? buf_data[`DARS_RES_W-1:0] : '0;

  // Bit on the pin is the shifter top; it is zero right at select fall
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_first_q  <= '0;
      sh_second_q <= '0;
    end else if (cs_fall) begin
      sh_first_q  <= dars_pkg::dars_frame(load_first, load_second);
      sh_second_q <= dars_pkg::dars_frame(load_second, load_first);
    end else if (ck_fall && shifting) begin
      sh_first_q  <= {sh_first_q[`DARS_FRAME_BITS-2:0], 1'b0};
      sh_second_q <= {sh_second_q[`DARS_FRAME_BITS-2:0], 1'b0};
    end
  end

  // Data changes only on falling edges, so a slow host may sample on rises
  assign serial_out_first  = sh_first_q[`DARS_FRAME_BITS-1];
  assign serial_out_second = sh_second_q[`DARS_FRAME_BITS-1];

  //////////////////////////////////////////////////////////////////////////
  // Line drive enables
  logic oe_q;

  // Both lines are driven together in either read style
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_q <= 1'b0;
    end else if (cs_rise) begin
      oe_q <= 1'b0;
    end else if (cs_fall) begin
      oe_q <= 1'b1;
    end else if (ck_fall && fall_reaches(state_q, dars_pkg::DARS_SECOND,
                                         falls_d, `DARS_LAST_FALL)) begin
      oe_q <= 1'b0;
    end
  end

  assign serial_out_first_oe  = oe_q;
  assign serial_out_second_oe = oe_q;

  //////////////////////////////////////////////////////////////////////////
  // Track and hold, conversion activity
  // Hold runs to the rise after fall 13; a cut frame releases it at select rise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 1'b0;
    end else if (cs_rise) begin
      hold_q <= 1'b0;
    end else if (cs_fall) begin
      hold_q <= 1'b1;
    end else if (ck_rise && falls_q >= `DARS_HOLD_FALLS) begin
      hold_q <= 1'b0;
    end
  end

  // Conversion needs fourteen falls; an early select rise aborts it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      convert_q <= 1'b0;
    end else if (cs_rise) begin
      convert_q <= 1'b0;
    end else if (cs_fall) begin
      convert_q <= 1'b1;
    end else if (ck_fall && fall_reaches(state_q, dars_pkg::DARS_FIRST,
                                         falls_d, `DARS_CONV_FALLS)) begin
      convert_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sample strobe to the core and missing-result flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_q  <= 1'b0;
      missing_q <= 1'b0;
    end else begin
      sample_q <= cs_fall;
      if (cs_fall) missing_q <= !buf_valid;
    end
  end

endmodule : dars_top

/* File: dars_top_bench.sv */
// Self-checking bench of the serial readout block
`timescale 1ns/1ps
module dars_top_bench;
  logic        clk;
  logic        rst_b;
  logic [11:0] r_a;
  logic [11:0] r_b;
  logic        r_v;
  logic        rdy, d_a, oe_a, d_b, oe_b, hold, smp, conv, miss, fs_b, sclk;
  logic [31:0] cap_a, cap_b;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  // A released line shows the inverse of its bit, so a capture there never matches
  wire         ln_a = oe_a ? d_a : ~d_a;
  wire         ln_b = oe_b ? d_b : ~d_b;
  always #12.5 clk = ~clk;
  dars_top dars_top_inst (.clk(clk), .rst_b(rst_b), .frame_sel_b(fs_b), .sclk(sclk),
    .res_first(r_a), .res_second(r_b), .res_valid(r_v), .res_ready(rdy),
    .serial_out_first(d_a), .serial_out_first_oe(oe_a), .serial_out_second(d_b),
    .serial_out_second_oe(oe_b), .hold_q(hold), .sample_q(smp), .convert_q(conv),
    .missing_q(miss));
  dars_host dars_host_inst (.clk(clk), .frame_sel_b(fs_b), .sclk(sclk), .line_a(ln_a),
    .line_b(ln_b), .cap_a(cap_a), .cap_b(cap_b));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [15:0] sub(input logic [11:0] r);
    return {2'h0, r, 2'h0};
  endfunction : sub
  // Offer one pair; valid holds until ready was up at an edge
  task automatic push(input logic [11:0] a, input logic [11:0] b);
    r_a = a;
    r_b = b;
    r_v = 1'b1;
    while (rdy !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
    r_v = 1'b0;
    @(posedge clk) #1; // Let an edge pass before the next offer
  endtask : push
  task automatic t_pair();
    push(12'ha5c, 12'h3f1);
    dars_host_inst.run(16, 1'b0);
    chk(cap_a, {16'h0000, sub(12'ha5c)});
    chk(cap_b, {16'h0000, sub(12'h3f1)});
    chk({29'h0000_0000, oe_a, oe_b, miss}, 32'h0000_0000);
    $display("test pair done");
  endtask : t_pair
  // Slow host reads on rises: second leading zero, result, then three zeros
  task automatic t_rise();
    push(12'h5a3, 12'h0c6);
    dars_host_inst.run(16, 1'b1);
    chk(cap_a, {16'h0000, 1'b0, 12'h5a3, 3'h0});
    chk(cap_b, {16'h0000, 1'b0, 12'h0c6, 3'h0});
    $display("test rise done");
  endtask : t_rise
  task automatic t_dual();
    push(12'h800, 12'h001);
    dars_host_inst.run(32, 1'b0);
    chk(cap_a, {sub(12'h800), sub(12'h001)});
    chk(cap_b, {sub(12'h001), sub(12'h800)});
    $display("test dual done");
  endtask : t_dual
  // Two pairs fill the buffer; frames drain it, then one finds it empty
  task automatic t_buffer();
    push(12'h123, 12'h456);
    push(12'hfed, 12'hcba);
    chk({31'h0000_0000, rdy}, 32'h0000_0000);
    dars_host_inst.run(14, 1'b0);
    chk(cap_a, {20'h0_0000, 12'h123});
    chk({31'h0000_0000, rdy}, 32'h0000_0001);
    dars_host_inst.run(14, 1'b0);
    chk(cap_b, {20'h0_0000, 12'hcba});
    dars_host_inst.run(14, 1'b0);
    chk(cap_a, 32'h0000_0000);
    chk({31'h0000_0000, miss}, 32'h0000_0001);
    $display("test buffer done");
  endtask : t_buffer
  // Six captures: two leading zeros, then four result bits, then a cut
  task automatic t_abort();
    push(12'hfff, 12'hfff);
    dars_host_inst.run(6, 1'b0);
    chk(cap_a, 32'h0000_000f);
    chk({29'h0000_0000, oe_a, conv, hold}, 32'h0000_0000);
    $display("test abort done");
  endtask : t_abort
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    clk   = 1'b0;
    rst_b = 1'b0;
    r_a   = 12'h000;
    r_b   = 12'h000;
    r_v   = 1'b0;
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    t_pair();
    t_rise();
    t_dual();
    t_buffer();
    t_abort();
    print_verdict();
  end
endmodule : dars_top_bench
bind dars_top dars_top_sva dars_top_sva_inst (.clk(clk), .rst_b(rst_b),
  .frame_sel_b(frame_sel_b), .sclk(sclk), .serial_out_first(serial_out_first),
  .serial_out_first_oe(serial_out_first_oe), .serial_out_second_oe(serial_out_second_oe),
  .hold_q(hold_q), .sample_q(sample_q), .convert_q(convert_q));

/* File: dars_top_sva.sv */
// Checker of the readout frame timing
`timescale 1ns/1ps
module dars_top_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic frame_sel_b,
  input wire logic sclk,
  input wire logic serial_out_first,
  input wire logic serial_out_first_oe,
  input wire logic serial_out_second_oe,
  input wire logic hold_q,
  input wire logic sample_q,
  input wire logic convert_q
);
  logic [5:0] n_q;
  logic       sclk_q;
  // Raw pin falls in a frame; the design sees them some cycles later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      n_q    <= 6'h00;
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
      if (frame_sel_b) n_q <= 6'h00;
      else if (sclk_q && !sclk) n_q <= n_q + 6'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_start; $fell(frame_sel_b); endsequence
  sequence s_on; sample_q && hold_q && convert_q && serial_out_first_oe; endsequence
  a_fall_starts_frame: assert property (s_start |-> ##[2:5] s_on)
    else $error("frame start missed");
  a_sample_one_pulse: assert property (sample_q |=> !sample_q)
    else $error("sample pulse too long");
  a_first_bit_zero: assert property (sample_q |-> !serial_out_first)
    else $error("first bit not zero");
  a_hold_kept: assert property (!frame_sel_b && n_q inside {[1:12]} |-> hold_q)
    else $error("hold left early");
  a_track_after_13: assert property (!frame_sel_b && n_q == 6'h0d && $rose(sclk)
    |-> ##[1:5] !hold_q)
    else $error("hold not left");
  a_conv_ends_14: assert property (!frame_sel_b && n_q == 6'h0e |-> ##5 !convert_q)
    else $error("conversion still on");
  a_release_at_32: assert property (!frame_sel_b && n_q == 6'h20
    |-> ##5 !serial_out_first_oe)
    else $error("line kept after 32");
  a_rise_releases: assert property ($rose(frame_sel_b)
    |-> ##[1:5] !serial_out_first_oe && !convert_q && !hold_q)
    else $error("select rise not obeyed");
  a_lines_enabled_together: assert property (serial_out_first_oe == serial_out_second_oe)
    else $error("line enables differ");
endmodule : dars_top_sva
